// *** src/ddsc_pkg.sv ***
package ddsc_pkg;

  // Register byte addresses on the APB bus.
  localparam logic [7:0] ADDR_FIRST_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_SECOND_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_FIRST_TUNING = 8'h08;
  localparam logic [7:0] ADDR_FIRST_OFFSET = 8'h0C;
  localparam logic [7:0] ADDR_START = 8'h10;
  localparam logic [7:0] ADDR_STOP = 8'h14;
  localparam logic [7:0] ADDR_RISE = 8'h18;
  localparam logic [7:0] ADDR_FALL = 8'h1C;
  localparam logic [7:0] ADDR_RATES = 8'h20;
  localparam logic [7:0] ADDR_RAM0 = 8'h24;
  localparam logic [7:0] ADDR_RAM3 = 8'h30;
  localparam logic [7:0] ADDR_UPDATE = 8'h34;
  localparam logic [7:0] ADDR_STATUS = 8'h38;
  localparam logic [7:0] ADDR_PHASE = 8'h3C;

  // Widths and field positions.
  localparam int ACC_W = 32;
  localparam int OFFS_W = 14;
  localparam int LUT_W = 19;
  localparam int MULT_LSB = 3;
  localparam int MULT_MSB = 7;
  localparam int RAM_OFFS_LSB = 18;
  localparam int RISE_RATE_LSB = 0;
  localparam int FALL_RATE_LSB = 8;
  localparam logic [4:0] MULT_MIN = 5'h04;
  localparam logic [4:0] MULT_MAX = 5'h14;

  // Reset values: the active clear-phase bit starts set, its buffer starts clear.
  localparam logic [31:0] CTRL1_ACTIVE_RST = 32'h00000400;
  localparam logic [31:0] CTRL1_BUFFER_RST = 32'h00000000;
  localparam logic [31:0] CTRL2_RST = 32'h00000000;

  // Multiplier lock time.
  localparam int CLK_MHZ = 250;
  localparam int LOCK_TIME_US = 1000;
  localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;

  // Phase offset pipeline depth, equal to the tuning word path.
  localparam int OFFS_DELAY = 2;

  typedef struct packed {
    logic ram_en;
    logic ram_dest;
    logic [3:0] rsv_29_26;
    logic keying_en;
    logic keying_auto;
    logic [1:0] rsv_23_22;
    logic sweep_en;
    logic [5:0] rsv_20_15;
    logic ac_sweep;
    logic ac_phase;
    logic rsv_12;
    logic cc_sweep;
    logic cc_phase;
    logic [2:0] rsv_9_7;
    logic comp_pd;
    logic rsv_5;
    logic clk_stop;
    logic rsv_3;
    logic no_dwell;
    logic [1:0] rsv_1_0;
  } ddsc_ctrl1_s;

endpackage : ddsc_pkg

// *** src/ddsc_core.sv ***
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module ddsc_core
  import ddsc_pkg::*;
#(
  parameter int LOCK_CYCLES_P = LOCK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic io_update,
  input wire logic profile_select_bit0,
  input wire logic profile_select_bit1,
  input wire logic oscillator_select_pin,
  output logic [LUT_W-1:0] cos_phase,
  output logic oscillator_enable,
  output logic sysclk_running,
  output logic [4:0] pll_multiplier,
  output logic pll_enable,
  output logic pll_locked,
  output logic comparator_power_down,
  output logic shaped_amplitude_keying,
  output logic keying_auto_mode
);

  ddsc_ctrl1_s act_ctrl1;
  ddsc_ctrl1_s buf_ctrl1;
  logic [31:0] act_ctrl2, buf_ctrl2;
  logic [31:0] act_tune0, buf_tune0;
  logic [OFFS_W-1:0] act_offs0, buf_offs0;
  logic [31:0] act_start, buf_start;
  logic [31:0] act_stop, buf_stop;
  logic [31:0] act_rise, buf_rise;
  logic [31:0] act_fall, buf_fall;
  logic [15:0] act_rates, buf_rates;
  logic [31:0] ram_mem [4];
  logic [1:0] profile, profile_q;
  logic profile_change, update_evt, wr_en, rd_setup, run;
  logic clr_phase, clr_sweep;
  logic [ACC_W-1:0] phase_acc, tune_q, next_tune, sweep_acc;
  logic [OFFS_W-1:0] next_offs;
  logic [OFFS_W-1:0] offs_pipe [OFFS_DELAY];
  logic [7:0] ramp_cnt;
  logic [31:0] lock_cnt;
  logic [4:0] mult_q;

  function automatic logic mult_in_range(input logic [4:0] m);
    mult_in_range = (m >= MULT_MIN) && (m <= MULT_MAX);
  endfunction : mult_in_range

  function automatic logic in_ram(input logic [7:0] a);
    in_ram = (a >= ADDR_RAM0) && (a <= ADDR_RAM3) && (a[1:0] == 2'b00);
  endfunction : in_ram

  assign profile = {profile_select_bit1, profile_select_bit0};
  assign profile_change = (profile != profile_q);
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign update_evt = io_update || profile_change || (wr_en && paddr == ADDR_UPDATE);
  assign run = !act_ctrl1.clk_stop;
  // Auto-clear looks at the buffered bit because the same strobe makes it active.
  assign clr_phase = act_ctrl1.cc_phase || (update_evt && buf_ctrl1.ac_phase);
  assign clr_sweep = act_ctrl1.cc_sweep || (update_evt && buf_ctrl1.ac_sweep);

  // Zero-wait slave; every access completes in its first access cycle.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(paddr <= ADDR_PHASE && paddr[1:0] == 2'b00);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      profile_q <= 2'b00;
    end else begin
      profile_q <= profile;
    end
  end

  // Buffer registers written by software.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_ctrl1 <= ddsc_ctrl1_s'(CTRL1_BUFFER_RST);
      buf_ctrl2 <= CTRL2_RST;
      buf_tune0 <= 32'h00000000;
      buf_offs0 <= 14'h0000;
      buf_start <= 32'h00000000;
      buf_stop <= 32'h00000000;
      buf_rise <= 32'h00000000;
      buf_fall <= 32'h00000000;
      buf_rates <= 16'h0000;
    end else if (wr_en) begin
      case (paddr)
        ADDR_FIRST_CONTROL: buf_ctrl1 <= ddsc_ctrl1_s'(pwdata);
        ADDR_SECOND_CONTROL: buf_ctrl2 <= pwdata;
        ADDR_FIRST_TUNING: buf_tune0 <= pwdata;
        ADDR_FIRST_OFFSET: buf_offs0 <= pwdata[OFFS_W-1:0];
        ADDR_START: buf_start <= pwdata;
        ADDR_STOP: buf_stop <= pwdata;
        ADDR_RISE: buf_rise <= pwdata;
        ADDR_FALL: buf_fall <= pwdata;
        ADDR_RATES: buf_rates <= pwdata[15:0];
        default: begin
        end
      endcase
    end
  end

  // The RAM is written directly; it holds one word per profile.
  always_ff @(posedge pclk) begin
    if (wr_en && in_ram(paddr)) begin
      ram_mem[2'(paddr[7:2] - ADDR_RAM0[7:2])] <= pwdata;
    end
  end

  // Active registers follow the buffers only on an update strobe.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_ctrl1 <= ddsc_ctrl1_s'(CTRL1_ACTIVE_RST);
      act_ctrl2 <= CTRL2_RST;
      act_tune0 <= 32'h00000000;
      act_offs0 <= 14'h0000;
      act_start <= 32'h00000000;
      act_stop <= 32'h00000000;
      act_rise <= 32'h00000000;
      act_fall <= 32'h00000000;
      act_rates <= 16'h0000;
    end else if (update_evt) begin
      act_ctrl1 <= buf_ctrl1;
      act_ctrl2 <= buf_ctrl2;
      act_tune0 <= buf_tune0;
      act_offs0 <= buf_offs0;
      act_start <= buf_start;
      act_stop <= buf_stop;
      act_rise <= buf_rise;
      act_fall <= buf_fall;
      act_rates <= buf_rates;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      if (in_ram(paddr)) begin
        prdata <= ram_mem[2'(paddr[7:2] - ADDR_RAM0[7:2])];
      end else begin
        case (paddr)
          ADDR_FIRST_CONTROL: prdata <= buf_ctrl1;
          ADDR_SECOND_CONTROL: prdata <= buf_ctrl2;
          ADDR_FIRST_TUNING: prdata <= buf_tune0;
          ADDR_FIRST_OFFSET: prdata <= {18'h00000, buf_offs0};
          ADDR_START: prdata <= buf_start;
          ADDR_STOP: prdata <= buf_stop;
          ADDR_RISE: prdata <= buf_rise;
          ADDR_FALL: prdata <= buf_fall;
          ADDR_RATES: prdata <= {16'h0000, buf_rates};
          ADDR_STATUS: prdata <= {24'h000000, profile, 2'b00, pll_enable, pll_locked,
                                  run, act_ctrl1.cc_phase};
          ADDR_PHASE: prdata <= phase_acc;
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Tuning and offset source selection.
  always_comb begin
    if (act_ctrl1.ram_en && !act_ctrl1.ram_dest) begin
      next_tune = ram_mem[profile];
    end else if (act_ctrl1.sweep_en) begin
      next_tune = sweep_acc;
    end else begin
      next_tune = act_tune0;
    end
    if (act_ctrl1.ram_en && act_ctrl1.ram_dest) begin
      next_offs = ram_mem[profile][31:RAM_OFFS_LSB];
    end else begin
      next_offs = act_offs0;
    end
  end

  // The tuning word is registered once and then accumulated; the offset gets the
  // same two-stage delay so a combined phase and frequency change lands together.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tune_q <= 32'h00000000;
      offs_pipe[0] <= 14'h0000;
      offs_pipe[1] <= 14'h0000;
    end else if (run) begin
      tune_q <= next_tune;
      offs_pipe[0] <= next_offs;
      offs_pipe[1] <= offs_pipe[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_acc <= 32'h00000000;
    end else if (clr_phase) begin
      phase_acc <= 32'h00000000;
    end else if (run) begin
      phase_acc <= phase_acc + tune_q;
    end
  end

  // Offset sits at the top of the word: one step is 1/2^14 of a turn.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cos_phase <= 19'h00000;
    end else if (run) begin
      cos_phase <= 19'((phase_acc + {offs_pipe[1], 18'h00000}) >> (ACC_W - LUT_W));
    end
  end

  // Linear sweep: profile bit 0 gives direction, rates are cycles between steps.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sweep_acc <= 32'h00000000;
      ramp_cnt <= 8'h00;
    end else if (clr_sweep) begin
      sweep_acc <= act_start;
      ramp_cnt <= 8'h00;
    end else if (run && act_ctrl1.sweep_en) begin
      if (ramp_cnt != 8'h00) begin
        ramp_cnt <= ramp_cnt - 8'h01;
      end else if (profile_select_bit0) begin
        ramp_cnt <= act_rates[RISE_RATE_LSB +: 8];
        if ({1'b0, sweep_acc} + {1'b0, act_rise} >= {1'b0, act_stop}) begin
          sweep_acc <= act_ctrl1.no_dwell ? act_start : act_stop;
        end else begin
          sweep_acc <= sweep_acc + act_rise;
        end
      end else begin
        ramp_cnt <= act_rates[FALL_RATE_LSB +: 8];
        if ({1'b0, sweep_acc} <= {1'b0, act_start} + {1'b0, act_fall}) begin
          sweep_acc <= act_start;
        end else begin
          sweep_acc <= sweep_acc - act_fall;
        end
      end
    end
  end

  // Any change of the multiplier field restarts the lock wait.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mult_q <= 5'h00;
      lock_cnt <= 32'h00000000;
      pll_locked <= 1'b0;
    end else begin
      mult_q <= act_ctrl2[MULT_MSB:MULT_LSB];
      if (!mult_in_range(act_ctrl2[MULT_MSB:MULT_LSB])) begin
        lock_cnt <= 32'h00000000;
        pll_locked <= 1'b0;
      end else if (mult_q != act_ctrl2[MULT_MSB:MULT_LSB]) begin
        lock_cnt <= 32'h00000000;
        pll_locked <= 1'b0;
      end else if (lock_cnt == 32'(LOCK_CYCLES_P - 1)) begin
        pll_locked <= 1'b1;
      end else begin
        lock_cnt <= lock_cnt + 32'h00000001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_multiplier <= 5'h00;
      pll_enable <= 1'b0;
      oscillator_enable <= 1'b0;
      sysclk_running <= 1'b0;
      comparator_power_down <= 1'b0;
      shaped_amplitude_keying <= 1'b0;
      keying_auto_mode <= 1'b0;
    end else begin
      pll_multiplier <= act_ctrl2[MULT_MSB:MULT_LSB];
      pll_enable <= mult_in_range(act_ctrl2[MULT_MSB:MULT_LSB]) && run;
      oscillator_enable <= oscillator_select_pin && run;
      sysclk_running <= run;
      comparator_power_down <= act_ctrl1.comp_pd;
      shaped_amplitude_keying <= act_ctrl1.keying_en;
      keying_auto_mode <= act_ctrl1.keying_auto;
    end
  end

  ac_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    act_ctrl1.cc_phase |=> phase_acc == 32'h00000000)
    else $error("continuous clear did not hold the accumulator at zero");
  acc_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    run && !clr_phase |=> phase_acc == $past(phase_acc) + $past(tune_q))
    else $error("accumulator did not add the tuning word");
  reset_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) || !$past(presetn) |-> act_ctrl1.cc_phase)
    else $error("clear bit not set after reset");
  xfer_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
    update_evt |=> act_ctrl1 == $past(buf_ctrl1) && act_tune0 == $past(buf_tune0))
    else $error("update did not copy buffers");
  no_xfer_a: assert property (@(posedge pclk) disable iff (!presetn)
    !update_evt |=> $stable(act_tune0) && $stable(act_ctrl1))
    else $error("active register changed without update");
  offs_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
    run [*3] |-> offs_pipe[1] == $past(next_offs, 2))
    else $error("offset path delay mismatch");
  auto_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    update_evt && buf_ctrl1.ac_phase |=> phase_acc == 32'h00000000)
    else $error("auto clear missed");
  // The running flag is registered, so it must already be low one cycle after the stop.
  stop_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
    !run && !clr_phase |=> $stable(phase_acc) && !sysclk_running)
    else $error("stopped clock still advanced the core");
  comp_pd_a: assert property (@(posedge pclk) disable iff (!presetn)
    act_ctrl1.comp_pd |=> comparator_power_down)
    else $error("comparator not powered down");
  pll_bypass_a: assert property (@(posedge pclk) disable iff (!presetn)
    !mult_in_range(act_ctrl2[MULT_MSB:MULT_LSB]) |=> !pll_enable && !pll_locked)
    else $error("multiplier enabled out of range");
  tune_mux_a: assert property (@(posedge pclk) disable iff (!presetn)
    !act_ctrl1.ram_en && !act_ctrl1.sweep_en && run |=> tune_q == $past(act_tune0))
    else $error("wrong tuning word source");
  sweep_top_a: assert property (@(posedge pclk) disable iff (!presetn)
    act_ctrl1.sweep_en && run && !clr_sweep && act_stop >= act_start |=>
      sweep_acc <= $past(act_stop) || $past(sweep_acc) > $past(act_stop))
    else $error("sweep passed terminal word");
  sweep_floor_a: assert property (@(posedge pclk) disable iff (!presetn)
    act_ctrl1.sweep_en && run && !clr_sweep && !profile_select_bit0 |=>
      sweep_acc >= $past(act_start) || $past(sweep_acc) < $past(act_start))
    else $error("falling sweep passed start word");
  keying_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    act_ctrl1.keying_en && act_ctrl1.keying_auto |=> shaped_amplitude_keying && keying_auto_mode)
    else $error("shaped keying outputs do not follow control bits");
  osc_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !oscillator_select_pin |=> !oscillator_enable)
    else $error("oscillator enabled with select pin low");
  // Lock may only be reported while the registered multiplier copy mult_q is in range.
  lock_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    pll_locked |-> mult_in_range(mult_q))
    else $error("lock reported for bypassed multiplier");

  first_update_c: cover property (@(posedge pclk) disable iff (!presetn)
    act_ctrl1.cc_phase ##1 !act_ctrl1.cc_phase);
  profile_hop_c: cover property (@(posedge pclk) disable iff (!presetn)
    profile_change && act_ctrl1.ram_en);
  sweep_end_c: cover property (@(posedge pclk) disable iff (!presetn)
    act_ctrl1.sweep_en && sweep_acc == act_stop);
  no_dwell_c: cover property (@(posedge pclk) disable iff (!presetn)
    act_ctrl1.sweep_en && act_ctrl1.no_dwell && sweep_acc == act_start);
  pll_lock_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(pll_locked));

endmodule : ddsc_core

// *** sim/ddsc_dac_model.sv ***
`timescale 1ns/1ps
// Stand-in for the converter: it takes one phase sample per clock.
// Amplitude mapping is outside this block, so it only counts how often the sample moves.
module ddsc_dac_model
  import ddsc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [LUT_W-1:0] cos_phase,
  output int moves
);
  logic [LUT_W-1:0] last;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last <= '0;
      moves <= 0;
    end else begin
      last <= cos_phase;
      if (cos_phase != last) begin
        moves <= moves + 1;
      end
    end
  end
endmodule : ddsc_dac_model

// *** sim/tb_dds_core_tuning_datapath.sv ***
`timescale 1ns/1ps
module tb_dds_core_tuning_datapath;
  import ddsc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic io_update = 1'b0;
  logic profile_select_bit0 = 1'b0;
  logic profile_select_bit1 = 1'b0;
  logic oscillator_select_pin = 1'b1;
  logic [LUT_W-1:0] cos_phase;
  logic oscillator_enable, sysclk_running, pll_enable, pll_locked;
  logic comparator_power_down, shaped_amplitude_keying, keying_auto_mode;
  logic [4:0] pll_multiplier;
  logic [31:0] rd;
  logic [31:0] a;
  logic serr;
  int dac_moves;
  int n_errors = 0;
  int checks_done = 0;

  always #2 pclk = ~pclk;

  // A short lock count of 20 keeps the run small; the lock check allows up to twice that figure.
  ddsc_core #(.LOCK_CYCLES_P(20)) u_ddsc_core (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .io_update(io_update), .profile_select_bit0(profile_select_bit0),
    .profile_select_bit1(profile_select_bit1), .oscillator_select_pin(oscillator_select_pin),
    .cos_phase(cos_phase), .oscillator_enable(oscillator_enable),
    .sysclk_running(sysclk_running), .pll_multiplier(pll_multiplier),
    .pll_enable(pll_enable), .pll_locked(pll_locked),
    .comparator_power_down(comparator_power_down),
    .shaped_amplitude_keying(shaped_amplitude_keying), .keying_auto_mode(keying_auto_mode));

  ddsc_dac_model u_ddsc_dac_model (.pclk(pclk), .presetn(presetn), .cos_phase(cos_phase),
    .moves(dac_moves));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // The request stays put until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      n_errors++;
      end_of_test();
    end
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic upd();
    apb(1'b1, ADDR_UPDATE, 32'h00000000);
    repeat (8) @(posedge pclk);
  endtask : upd

  task automatic cfg(input logic [31:0] c1, input logic [31:0] tw, input logic [31:0] pw);
    apb(1'b1, ADDR_FIRST_CONTROL, c1);
    apb(1'b1, ADDR_FIRST_TUNING, tw);
    apb(1'b1, ADDR_FIRST_OFFSET, pw);
    upd();
  endtask : cfg

  // Two reads of the accumulator sit three cycles apart at their setup edges.
  task automatic rate(input string what, input logic [31:0] step);
    apb(1'b0, ADDR_PHASE, 32'h00000000);
    a = rd;
    apb(1'b0, ADDR_PHASE, 32'h00000000);
    chk(what, step * 32'h00000003, rd - a);
  endtask : rate

  task automatic cos_chk(input logic [31:0] off);
    logic [31:0] s;
    apb(1'b0, ADDR_PHASE, 32'h00000000);
    s = rd + off;
    chk("cos phase", {13'h0000, s[31:13]}, {13'h0000, cos_phase});
  endtask : cos_chk

  task automatic t_reset();
    apb(1'b0, ADDR_STATUS, 32'h00000000);
    chk("clear bit", 32'h00000001, {31'h0, rd[0]});
    repeat (10) @(posedge pclk);
    rate("held phase", 32'h00000000);
    chk("held phase value", 32'h00000000, a);
    apb(1'b0, ADDR_FIRST_CONTROL, 32'h00000000);
    chk("control buffer", CTRL1_BUFFER_RST, rd);
    apb(1'b0, 8'h40, 32'h00000000);
    chk("unmapped", 32'h00000001, {31'h0, serr});
    $display("test reset done");
  endtask : t_reset

  task automatic t_accum();
    cfg(32'h00000000, 32'hFFFFFFF0, 32'h00000000);
    rate("wrapping step", 32'hFFFFFFF0);
    cfg(32'h00000000, 32'h00012345, 32'h00000000);
    rate("plain step", 32'h00012345);
    chk("dac sees motion", 32'h00000001, {31'h0, dac_moves > 0});
    $display("test accumulate done");
  endtask : t_accum

  task automatic t_offset();
    cfg(32'h00000000, 32'h00000000, 32'h00002001);
    rate("frozen", 32'h00000000);
    cos_chk(32'h80040000);
    $display("test offset done");
  endtask : t_offset

  task automatic t_clear();
    logic [31:0] first;
    cfg(32'h00000400, 32'h00001000, 32'h00000000);
    rate("continuous clear", 32'h00000000);
    chk("cleared value", 32'h00000000, a);
    cfg(32'h00002800, 32'h00001000, 32'h00000000);
    for (int k = 0; k < 4; k++) begin
      if (k < 2) begin
        io_update <= 1'b1;
        @(posedge pclk);
        io_update <= 1'b0;
      end else begin
        profile_select_bit1 <= ~profile_select_bit1;
      end
      repeat (6) @(posedge pclk);
      apb(1'b0, ADDR_PHASE, 32'h00000000);
      if (k % 2 == 0) begin
        first = rd;
        chk("restarted running", 32'h00000001, {31'h0, rd != 0});
      end else begin
        chk("restart point", first, rd);
      end
    end
    $display("test clear done");
  endtask : t_clear

  task automatic t_ctrl();
    logic [4:0] m[4] = '{5'h03, 5'h04, 5'h14, 5'h15};
    int n;
    apb(1'b1, ADDR_SECOND_CONTROL, 32'h000000A0);
    cfg(32'h03000050, 32'h00000000, 32'h00000000);
    chk("outputs", 32'h0000001C, {27'h0, comparator_power_down, shaped_amplitude_keying,
      keying_auto_mode, sysclk_running, oscillator_enable});
    n = 0;
    while (pll_locked !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk("lock in time", 32'h00000001, {31'h0, n < 40});
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, ADDR_SECOND_CONTROL, {24'h0, m[k], 3'h0});
      cfg(32'h00000000, 32'h00000000, 32'h00000000);
      chk("multiplier", {27'h0, m[k]}, {27'h0, pll_multiplier});
      chk("pll on", {31'h0, k == 1 || k == 2}, {31'h0, pll_enable});
      chk("running", 32'h00000003, {30'h0, sysclk_running, oscillator_enable});
    end
    oscillator_select_pin <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("oscillator off", 32'h00000002, {30'h0, sysclk_running, oscillator_enable});
    oscillator_select_pin <= 1'b1;
    $display("test control done");
  endtask : t_ctrl

  task automatic t_ram();
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, ADDR_RAM0 + 8'(4 * p), 32'h00000100 * (p + 1));
    end
    cfg(32'h80000000, 32'h00000000, 32'h00000000);
    for (int p = 0; p < 4; p++) begin
      profile_select_bit0 <= p[0];
      profile_select_bit1 <= p[1];
      repeat (8) @(posedge pclk);
      rate("ram tuning", 32'h00000100 * (p + 1));
    end
    apb(1'b1, ADDR_RAM3, 32'h80000000);
    cfg(32'hC0000000, 32'h00000000, 32'h00000000);
    cos_chk(32'h80000000);
    $display("test ram done");
  endtask : t_ram

  task automatic t_sweep();
    profile_select_bit0 <= 1'b1;
    apb(1'b1, ADDR_START, 32'h00000100);
    apb(1'b1, ADDR_STOP, 32'h00001000);
    apb(1'b1, ADDR_RISE, 32'h00000100);
    apb(1'b1, ADDR_FALL, 32'h00000100);
    apb(1'b1, ADDR_RATES, 32'h00000000);
    cfg(32'h00200000, 32'h00000000, 32'h00000000);
    repeat (60) @(posedge pclk);
    rate("sweep terminal", 32'h00001000);
    profile_select_bit0 <= 1'b0;
    repeat (60) @(posedge pclk);
    rate("sweep floor", 32'h00000100);
    apb(1'b1, ADDR_STOP, 32'h00000200);
    profile_select_bit0 <= 1'b1;
    cfg(32'h00200004, 32'h00000000, 32'h00000000);
    repeat (20) @(posedge pclk);
    rate("no dwell", 32'h00000100);
    $display("test sweep done");
  endtask : t_sweep

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_accum();
    t_offset();
    t_clear();
    t_ctrl();
    t_ram();
    t_sweep();
    end_of_test();
  end
endmodule : tb_dds_core_tuning_datapath
